// [aidp_pkg.sv]
/*
  Package for the add-instruction datapath: opcode fields, addressing
  constants, Q-phase count and reset values.
  Assumes a core that presents one 16-bit instruction word per four-phase instruction cycle.
*/
package aidp_pkg;
  localparam int          AIDP_OP_W        = 16;
  localparam logic [7:0]  AIDP_OP_ADDLIT   = 8'h0f;
  localparam logic [5:0]  AIDP_OP_ADDMEM   = 6'h09;
  localparam int          AIDP_OPC_HI      = 15;
  localparam int          AIDP_BIT_D       = 9;
  localparam int          AIDP_BIT_A       = 8;
  localparam logic [7:0]  AIDP_ILO_LIMIT   = 8'h5f;
  localparam logic [7:0]  AIDP_ACC_SPLIT   = 8'h80;
  localparam logic [3:0]  AIDP_ACC_HI_BANK = 4'hf;
  localparam int          AIDP_QPHASES     = 4;
  localparam logic [7:0]  AIDP_W_RST       = 8'h00;
  localparam logic [4:0]  AIDP_FLAGS_RST   = 5'h00;
  localparam int          AIDP_FLG_C       = 0;
  localparam int          AIDP_FLG_HALF    = 1;
  localparam int          AIDP_FLG_Z       = 2;
  localparam int          AIDP_FLG_SWRAP   = 3;
  localparam int          AIDP_FLG_N       = 4;
  typedef enum logic [1:0] {AIDP_Q1, AIDP_Q2, AIDP_Q3, AIDP_Q4} aidp_q_e;
endpackage

// [aidp_adder.sv]
/*
  8-bit adder with status flag generation.
  Purely combinational; the caller registers the results.
*/
module aidp_adder
  import aidp_pkg::*;
(
  // Operands
  input  wire logic [7:0] op_a,
  input  wire logic [7:0] op_b,
  // Results
  output logic      [7:0] sum,
  output logic      [4:0] flags
);
  wire logic [8:0] full_sum = {1'b0, op_a} + {1'b0, op_b};
  wire logic [4:0] low_sum  = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
  wire logic       ovf      = (op_a[7] == op_b[7]) && (full_sum[7] != op_a[7]);

  assign sum = full_sum[7:0];
  always_comb begin
    flags              = '0;
    flags[AIDP_FLG_C]  = full_sum[8];
    flags[AIDP_FLG_HALF]  = low_sum[4];
    flags[AIDP_FLG_Z]     = (full_sum[7:0] == 8'h00);
    flags[AIDP_FLG_SWRAP] = ovf;
    flags[AIDP_FLG_N]  = full_sum[7];
  end
endmodule

// [aidp_core.sv]
/*
  Execution datapath for the literal-add and memory-add instructions.
  Assumes the core presents instr with instr_valid in Q1 of a
  four-phase instruction cycle, where the word is latched, and that data memory
  returns mem_rdata combinationally for mem_addr during Q2..Q3.
*/
// Contract
// - The memory-add opcode 0010 01da adds the accumulator to the byte at its file address.
// - With the destination bit clear the sum goes to the accumulator and memory is untouched.
// - With the destination bit set the sum is written back to the addressed memory byte.
// - With the access bit clear the file address resolves inside the fixed access bank.
// - With the access bit set the address is the bank selector joined with the file address.
// - With extended mode on and access bit clear, addresses up to 95 are indexed literal offsets.
module aidp_core
  import aidp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Instruction stream
  input  wire logic              instr_valid,
  input  wire logic [AIDP_OP_W-1:0] instr,
  // Addressing context
  input  wire logic [3:0]        bank_selector,
  input  wire logic              ext_mode_en,
  input  wire logic [11:0]       index_base,
  // Data memory
  input  wire logic [7:0]        mem_rdata,
  output logic      [11:0]       mem_addr,
  output logic      [7:0]        mem_wdata,
  output logic                   mem_we,
  // Status
  output logic      [7:0]        accumulator,
  output logic      [4:0]        status_flags,
  output logic      [1:0]        q_phase,
  output logic                   instr_done
);
  aidp_q_e      q_r, q_nxt;
  logic [7:0]   w_r, w_nxt;
  logic [4:0]   flg_r, flg_nxt;
  logic [11:0]  addr_r, addr_nxt;
  logic [7:0]   wd_r, wd_nxt;
  logic         we_r, we_nxt;
  logic         done_r, done_nxt;
  logic [7:0]   opnd_r, opnd_nxt;
  logic [AIDP_OP_W-1:0] ir_r, ir_nxt;

  // Phase decode
  wire logic        in_q1   = (q_r == AIDP_Q1);
  wire logic        in_q2   = (q_r == AIDP_Q2);
  wire logic        in_q4   = (q_r == AIDP_Q4);
  wire logic        take    = in_q1 && instr_valid;

  // Latched word keeps Q2..Q4 right even if the core moves on after Q1
  wire logic [AIDP_OP_W-1:0] cur_ins = in_q1 ? instr : ir_r;

  // Decode
  wire logic        is_lit  = cur_ins[AIDP_OPC_HI -: 8] == AIDP_OP_ADDLIT;
  wire logic        is_mem  = cur_ins[AIDP_OPC_HI -: 6] == AIDP_OP_ADDMEM;
  wire logic        dest_m  = cur_ins[AIDP_BIT_D];
  wire logic        acc_sel = cur_ins[AIDP_BIT_A];
  wire logic [7:0]  f_addr  = cur_ins[7:0];
  wire logic [7:0]  lit_k   = cur_ins[7:0];

  // Address formation
  wire logic        use_ilo  = ext_mode_en && !acc_sel && (f_addr <= AIDP_ILO_LIMIT);
  wire logic [11:0] ilo_addr = index_base + {4'h0, f_addr};
  wire logic [3:0]  acc_bank = (f_addr < AIDP_ACC_SPLIT) ? 4'h0 : AIDP_ACC_HI_BANK;
  wire logic [11:0] bank_addr = acc_sel ? {bank_selector, f_addr} : {acc_bank, f_addr};
  wire logic [11:0] eff_addr = use_ilo ? ilo_addr : bank_addr;

  // Arithmetic
  wire logic [7:0]  sum;
  wire logic [4:0]  sum_flags;
  aidp_adder aidp_adder_inst (
    .op_a  (w_r),
    .op_b  (opnd_r),
    .sum   (sum),
    .flags (sum_flags)
  );

  // Write-back selection, all in Q4
  wire logic        wr_acc   = in_q4 && (is_lit || (is_mem && !dest_m));
  wire logic        wr_mem   = in_q4 && is_mem && dest_m;
  wire logic        wr_flags = in_q4 && (is_lit || is_mem);

  // Phase sequencer
  always_comb begin
    q_nxt = q_r;
    case (q_r)
      AIDP_Q1: begin
        if (instr_valid) begin
          q_nxt = AIDP_Q2;
        end
      end
      AIDP_Q2: begin
        q_nxt = AIDP_Q3;
      end
      AIDP_Q3: begin
        q_nxt = AIDP_Q4;
      end
      AIDP_Q4: begin
        q_nxt = AIDP_Q1;
      end
      default: begin
        q_nxt = AIDP_Q1;
      end
    endcase
  end

  // Datapath next values
  always_comb begin
    ir_nxt   = ir_r;
    addr_nxt = addr_r;
    opnd_nxt = opnd_r;
    w_nxt    = w_r;
    flg_nxt  = flg_r;
    wd_nxt   = wd_r;
    we_nxt   = wr_mem;
    done_nxt = in_q4;
    if (take) begin
      ir_nxt = instr;
    end
    if (take && is_mem) begin
      addr_nxt = eff_addr;
    end
    if (in_q2) begin
      opnd_nxt = is_lit ? lit_k : mem_rdata;
    end
    if (wr_acc) begin
      w_nxt = sum;
    end
    if (wr_flags) begin
      flg_nxt = sum_flags;
    end
    if (wr_mem) begin
      wd_nxt = sum;
    end
  end

  // One short block per register; reset branches load constants only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q_r <= AIDP_Q1;
    end else begin
      q_r <= q_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ir_r <= '0;
    end else begin
      ir_r <= ir_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      w_r <= AIDP_W_RST;
    end else begin
      w_r <= w_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flg_r <= AIDP_FLAGS_RST;
    end else begin
      flg_r <= flg_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_r <= '0;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      opnd_r <= '0;
    end else begin
      opnd_r <= opnd_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wd_r <= '0;
    end else begin
      wd_r <= wd_nxt;
    end
  end

  // Write strobe lands in the next Q1, after the sum is settled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      we_r <= 1'b0;
    end else begin
      we_r <= we_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign mem_addr     = addr_r;
  assign mem_wdata    = wd_r;
  assign mem_we       = we_r;
  assign accumulator  = w_r;
  assign status_flags = flg_r;
  assign q_phase      = q_r;
  assign instr_done   = done_r;
endmodule

// [aidp_core_monitor.sv]
/* Checker for aidp_core: phase walk, addressing and sums.
   Assumes instr and addressing inputs held through Q1..Q4. */
module aidp_mon
  import aidp_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Inputs of the core
  input wire logic        instr_valid,
  input wire logic [15:0] instr,
  input wire logic [3:0]  bank_selector,
  input wire logic        ext_mode_en,
  input wire logic [11:0] index_base,
  input wire logic [7:0]  mem_rdata,
  // Outputs of the core
  input wire logic [11:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_we,
  input wire logic [7:0]  accumulator,
  input wire logic [4:0]  status_flags,
  input wire logic [1:0]  q_phase,
  input wire logic        instr_done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire tk = q_phase == 2'h0 && instr_valid;
  wire ma = tk && instr[15:10] == AIDP_OP_ADDMEM;
  wire lo = !instr[8] && ext_mode_en && instr[7:0] <= AIDP_ILO_LIMIT;
  sequence s_steps;
    ##1 q_phase == 2'h1 ##1 q_phase == 2'h2 ##1 q_phase == 2'h3 ##1 instr_done;
  endsequence
  property p_steps; ma |-> s_steps; endproperty
  a_steps: assert property (p_steps) else $error("memory add phase walk wrong");
  property p_to_acc;
    ma && !instr[9] |-> ##4 !mem_we && accumulator == $past(accumulator, 4) + $past(mem_rdata, 2);
  endproperty
  a_to_acc: assert property (p_to_acc) else $error("sum to accumulator wrong");
  property p_to_mem;
    ma && instr[9] |-> ##4 mem_we && mem_wdata == $past(accumulator, 4) + $past(mem_rdata, 2);
  endproperty
  a_to_mem: assert property (p_to_mem) else $error("sum to memory wrong");
  property p_acc_bank;
    ma && !instr[8] && !lo |-> ##1 mem_addr == {instr[7] ? AIDP_ACC_HI_BANK : 4'h0, instr[7:0]};
  endproperty
  a_acc_bank: assert property (p_acc_bank) else $error("access bank address wrong");
  property p_banked; ma && instr[8] |-> ##1 mem_addr == {bank_selector, instr[7:0]}; endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");
  property p_indexed; ma && lo |-> ##1 mem_addr == index_base + {4'h0, instr[7:0]}; endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");
  property p_lit;
    tk && instr[15:8] == AIDP_OP_ADDLIT |-> ##4 instr_done && accumulator == $past(accumulator, 4)
      + $past(instr[7:0], 4) && status_flags[AIDP_FLG_Z] == (accumulator == 8'h00);
  endproperty
  a_lit: assert property (p_lit) else $error("literal add wrong");
endmodule
bind aidp_core aidp_mon aidp_mon_inst (
  .clk           (clk),
  .reset_n       (reset_n),
  .instr_valid   (instr_valid),
  .instr         (instr),
  .bank_selector (bank_selector),
  .ext_mode_en   (ext_mode_en),
  .index_base    (index_base),
  .mem_rdata     (mem_rdata),
  .mem_addr      (mem_addr),
  .mem_wdata     (mem_wdata),
  .mem_we        (mem_we),
  .accumulator   (accumulator),
  .status_flags  (status_flags),
  .q_phase       (q_phase),
  .instr_done    (instr_done)
);

// [aidp_core_tb.sv]
/* Testbench for aidp_core: both add forms, all addressing modes.
   Memory read data is a fixed function of the address. */
module aidp_core_tb
  import aidp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0, ext_mode_en = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [3:0]  bank_selector = 4'h0;
  logic [11:0] index_base = 12'h000, mem_addr;
  logic [7:0]  mem_wdata, accumulator, mem_rdata;
  logic [4:0]  status_flags;
  logic [1:0]  q_phase;
  logic        mem_we, instr_done, we_seen;
  int          num_errors = 0, cmp_count = 0, cyc = 0;
  // Address-derived data, so a wrong low address byte shows in the sum
  assign mem_rdata = mem_addr[7:0] + 8'h11;
  always #12.5 clk = ~clk;
  aidp_core aidp_core_inst (
    .clk           (clk),
    .reset_n       (reset_n),
    .instr_valid   (instr_valid),
    .instr         (instr),
    .bank_selector (bank_selector),
    .ext_mode_en   (ext_mode_en),
    .index_base    (index_base),
    .mem_rdata     (mem_rdata),
    .mem_addr      (mem_addr),
    .mem_wdata     (mem_wdata),
    .mem_we        (mem_we),
    .accumulator   (accumulator),
    .status_flags  (status_flags),
    .q_phase       (q_phase),
    .instr_done    (instr_done)
  );
  task wrap_up;
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      num_errors++;
      wrap_up;
    end
  end
  task chk(input string n, input logic [11:0] e, input logic [11:0] s);
    cmp_count++;
    if (e !== s) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task run(input logic [15:0] ins);
    @(posedge clk);
    instr <= ins;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (instr_done === 1'b1) break;
    end
    we_seen = mem_we;
    chk("done", 12'h001, {11'h000, instr_done});
  endtask
  task t_lit;
    run({AIDP_OP_ADDLIT, 8'h10});
    run({AIDP_OP_ADDLIT, 8'h15});
    chk("acc", 12'h025, {4'h0, accumulator});
    run({AIDP_OP_ADDLIT, 8'hf0});
    chk("acc", 12'h015, {4'h0, accumulator});
    chk("flags", 12'h001, {7'h00, status_flags});
  endtask
  task t_mem;
    bank_selector <= 4'h3;
    run({AIDP_OP_ADDMEM, 2'b01, 8'h42});
    chk("addr", 12'h342, mem_addr);
    chk("acc", 12'h068, {4'h0, accumulator});
    chk("we", 12'h000, {11'h000, we_seen});
    run({AIDP_OP_ADDMEM, 2'b10, 8'h90});
    chk("addr", 12'hf90, mem_addr);
    chk("wdata", 12'h009, {4'h0, mem_wdata});
    chk("we", 12'h001, {11'h000, we_seen});
    chk("acc", 12'h068, {4'h0, accumulator});
  endtask
  task t_ext;
    ext_mode_en <= 1'b1;
    index_base <= 12'h200;
    run({AIDP_OP_ADDMEM, 2'b00, 8'h5f});
    chk("addr", 12'h25f, mem_addr);
    chk("acc", 12'h0d8, {4'h0, accumulator});
    chk("flags", 12'h018, {7'h00, status_flags});
    // Just past the limit falls back to the access bank
    run({AIDP_OP_ADDMEM, 2'b00, 8'h60});
    chk("addr", 12'h060, mem_addr);
    chk("acc", 12'h049, {4'h0, accumulator});
    // Access bit set: extended mode has no say
    run({AIDP_OP_ADDMEM, 2'h1, 8'h10});
    chk("addr", 12'h310, mem_addr);
    chk("acc", 12'h06a, {4'h0, accumulator});
  endtask
  task t_other;
    // Unknown opcode: phases run, nothing else moves
    run(16'h0000);
    chk("acc", 12'h06a, {4'h0, accumulator});
    chk("flags", 12'h000, {7'h00, status_flags});
    chk("addr", 12'h310, mem_addr);
    chk("we", 12'h000, {11'h000, we_seen});
    // Wrap to zero sets carry, half carry and zero
    run({AIDP_OP_ADDLIT, 8'h96});
    chk("acc", 12'h000, {4'h0, accumulator});
    chk("flags", 12'h007, {7'h00, status_flags});
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_lit;
    t_mem;
    t_ext;
    t_other;
    wrap_up;
  end
endmodule
